// ---- hw/wit_timer.sv ----
/*
 * Watchdog / interval timer with a free-running prescaler and a selectable
 * overflow tap. Mode register written as a byte through a write strobe.
 * Assumes write strobes, mode inputs and flag clears come from logic on clk_sys.
 */
// Functional notes
// - Writing start bit 7 clears counter and starts; stopped while bit is zero.
// - Action bit and watchdog mode bit are sticky once set; only reset clears.
// - Start bit cannot be cleared by software; only reset clears it.
// - In interval mode counting starts at once when start bit set.
// - First overflow after restart may be up to 2^11 main clocks early; prescaler keeps running.
// - Setting watchdog mode while flag is one raises non-maskable interrupt.
// - Bit 4 set selects watchdog mode detecting a missing restart.
// - Watchdog detection time 2^11..2^17, 2^19 main clocks by select code.
// - Missed restart raises system reset or non-maskable interrupt per bit 3.
// - Keeps counting in light standby, halts in deep standby.
// - Counting suspended while CPU runs from subsystem oscillator.
// - Bit 4 clear gives repeated interval interrupts.
// - Interval time 2^12..2^18, 2^20 main clocks by select code.
// - Interval interrupt is maskable, obeys mask and priority flags.
// - Reset clears the whole mode register to zero.
`timescale 1ns/1ps
`include "wit_consts.svh"
module wit_timer
    import wit_pkg::*;
#(
    // Prescaler width; the base overflow step is 2^PRE_W clocks
    parameter int PRE_W = `WIT_PRESCALE_W,
    // Tap divider width; must cover the longest select code
    parameter int DIV_W = `WIT_DIV_W
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Mode register write port
    input wire logic wdt_mode_wr,
    input wire logic [7:0] wdt_mode_wdata,
    output logic [7:0] wdt_mode_reg,
    // Clock select field
    input wire wit_pkg::wit_sel_t timer_clk_select_two,
    // Power and clock state
    input wire logic deep_standby,
    input wire logic cpu_on_subclk,
    // Interrupt flags shared with the interrupt controller
    input wire logic wdt_irq_mask,
    input wire logic wdt_irq_priority,
    input wire logic wdt_irq_flag_clr,
    output logic wdt_irq_flag,
    // Events
    output logic wdt_interval_irq,
    output logic wdt_interval_irq_prio,
    output logic wdt_nmi,
    output logic wdt_sys_reset
);
    import wit_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Parameter checks: longest tap is code 7 plus the interval step
    if (DIV_W < (1 << `WIT_SEL_W) + 1) begin : g_div_check
        $error("wit_timer: DIV_W is too narrow for the longest overflow tap");
    end
    if (PRE_W < 1) begin : g_pre_check
        $error("wit_timer: PRE_W must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode state
    logic run_q, run_d;
    logic wdm_q, wdm_d;
    logic act_q, act_d;
    wit_sel_t sel_q, sel_d;
    // Counter state
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [DIV_W-1:0] div_q, div_d;
    // Event state
    logic flag_q, flag_d;
    logic nmi_q, nmi_d;
    logic rst_q, rst_d;
    logic irq_q, irq_d;
    // Decode
    logic tick, ovf, counting, run_set, wdm_rise;
    logic [`WIT_SEL_W:0] tap_k;
    logic [DIV_W-1:0] tap_mask;

    // Standby and subclock pause the prescaler as well
    assign counting = run_q && !deep_standby && !cpu_on_subclk;
    // Prescaler never cleared by restart, hence early first overflow
    assign tick = counting && (pre_q == {PRE_W{1'b1}});
    assign run_set = wdt_mode_wr && wdt_mode_wdata[`WIT_BIT_RUN];
    assign wdm_rise = wdm_d && !wdm_q;

    ////////////////////////////////////////////////////////////////////////
    // Overflow tap: base step from prescaler, interval mode one step longer,
    // code 7 one step further again in both modes
    always_comb begin
        tap_k = {1'b0, sel_q} + {{`WIT_SEL_W{1'b0}}, !wdm_q};
        if (sel_q == {`WIT_SEL_W{1'b1}}) begin
            tap_k = tap_k + {{`WIT_SEL_W{1'b0}}, 1'b1};
        end
        // Divider bits that must all be one at the tick; empty for the base step
        tap_mask = ({{(DIV_W-1){1'b0}}, 1'b1} << tap_k) - {{(DIV_W-1){1'b0}}, 1'b1};
        ovf = tick && ((div_q & tap_mask) == tap_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode group
    // Run, mode and action bits only ever set by software; reset is the one way back
    always_comb begin
        run_d = run_q | run_set;
        wdm_d = wdm_q;
        act_d = act_q;
        sel_d = sel_q;
        if (wdt_mode_wr) begin
            wdm_d = wdm_q | wdt_mode_wdata[`WIT_BIT_WDMODE];
            act_d = act_q | wdt_mode_wdata[`WIT_BIT_ACTION];
        end
        // Select follows the pin only while stopped
        // Freezing it avoids a torn tap if software breaks the rule
        if (!run_q) begin
            sel_d = timer_clk_select_two;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= 1'b0;
            wdm_q <= 1'b0;
            act_q <= 1'b0;
            sel_q <= '0;
        end else begin
            run_q <= run_d;
            wdm_q <= wdm_d;
            act_q <= act_d;
            sel_q <= sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter group
    // Prescaler shared by both modes and kept across restarts
    // Trade-off: a restart costs no prescaler reload, first period runs short
    always_comb begin
        pre_d = counting ? pre_q + {{(PRE_W-1){1'b0}}, 1'b1} : pre_q;
        div_d = div_q;
        if (run_set) begin
            div_d = '0;
        end else if (ovf) begin
            div_d = '0;
        end else if (tick) begin
            div_d = div_q + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= '0;
            div_q <= '0;
        end else begin
            pre_q <= pre_d;
            div_q <= div_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event group
    // A restart in the overflow cycle wins, so no event then
    always_comb begin
        // Set wins over a clear in the same cycle
        flag_d = (flag_q && !wdt_irq_flag_clr) || (ovf && !run_set);
        nmi_d = 1'b0;
        rst_d = 1'b0;
        irq_d = 1'b0;
        if (wdm_rise && flag_q) begin
            nmi_d = 1'b1;
        end
        if (ovf && !run_set) begin
            if (wdm_q) begin
                if (act_q) begin
                    rst_d = 1'b1;
                end else begin
                    nmi_d = 1'b1;
                end
            end else begin
                // Masked overflows still set the flag
                irq_d = !wdt_irq_mask;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 1'b0;
            nmi_q <= 1'b0;
            rst_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            nmi_q <= nmi_d;
            rst_q <= rst_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readback keeps unused mode bits at zero
    assign wdt_mode_reg = {run_q, 2'b00, wdm_q, act_q, 3'b000};
    assign wdt_irq_flag = flag_q;
    assign wdt_nmi = nmi_q;
    assign wdt_sys_reset = rst_q;
    assign wdt_interval_irq = irq_q;
    assign wdt_interval_irq_prio = irq_q & wdt_irq_priority;
endmodule

// ---- hw/wit_consts.svh ----
/*
 * Constants of the watchdog/interval timer: mode register field positions,
 * reset value and counter geometry.
 * Assumes inclusion by bare name from the package or design file.
 */
`ifndef WIT_CONSTS_SVH
`define WIT_CONSTS_SVH

`define WIT_MODE_RESET 8'h00
`define WIT_BIT_RUN 7
`define WIT_BIT_WDMODE 4
`define WIT_BIT_ACTION 3
`define WIT_PRESCALE_W 11
`define WIT_DIV_W 10
`define WIT_SEL_W 3

`endif

// ---- hw/wit_pkg.sv ----
/*
 * Types of the watchdog/interval timer.
 * Assumes wit_consts.svh is on the include path.
 */
package wit_pkg;
    `include "wit_consts.svh"
    typedef logic [`WIT_SEL_W-1:0] wit_sel_t;
    typedef enum logic {WIT_ACT_NMI, WIT_ACT_RESET} wit_action_t;
endpackage

// ---- dv/wit_timer_props.sv ----
/* Checker of wit_timer ports. Bound to every wit_timer. */
`timescale 1ns/1ps
module wit_timer_props (
    // Clock, reset, mode write
    input wire logic clk_sys, arst_n, wdt_mode_wr,
    input wire logic [7:0] wdt_mode_wdata, wdt_mode_reg,
    // Power state, mask, events
    input wire logic deep_standby, cpu_on_subclk, wdt_irq_mask,
    input wire logic wdt_interval_irq, wdt_nmi, wdt_sys_reset
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////
    property p_run; wdt_mode_wr && wdt_mode_wdata[7] |=> wdt_mode_reg[7]; endproperty
    a_run: assert property (p_run) else $error("run");
    property p_lock; (~wdt_mode_reg[4:3] & $past(wdt_mode_reg[4:3])) == 2'h0; endproperty
    a_lock: assert property (p_lock) else $error("lock");
    property p_set; wdt_mode_wr |=> wdt_mode_reg[4:3] == ($past(wdt_mode_reg[4:3]) | $past(wdt_mode_wdata[4:3])); endproperty
    a_set: assert property (p_set) else $error("set");
    property p_stop; !wdt_mode_reg[7] |-> !(wdt_interval_irq || wdt_nmi || wdt_sys_reset); endproperty
    a_stop: assert property (p_stop) else $error("stop");
    property p_mask; wdt_interval_irq |-> !$past(wdt_irq_mask) && !$past(wdt_mode_reg[4]); endproperty
    a_mask: assert property (p_mask) else $error("mask");
    property p_act; wdt_sys_reset |-> $past(wdt_mode_reg[3]) && $past(wdt_mode_reg[4]); endproperty
    a_act: assert property (p_act) else $error("act");
    property p_pause; $past(deep_standby || cpu_on_subclk) |-> !wdt_interval_irq && !wdt_sys_reset; endproperty
    a_pause: assert property (p_pause) else $error("pause");
    property p_one; wdt_sys_reset |=> !wdt_sys_reset; endproperty
    a_one: assert property (p_one) else $error("one");
    c_irq: cover property (wdt_interval_irq);
    c_nmi: cover property (wdt_nmi);
    c_rst: cover property (wdt_sys_reset);
endmodule
bind wit_timer wit_timer_props u_props (.*);

// ---- dv/tb_top.sv ----
/* Bench of wit_timer. Assumes the checker is compiled too. */
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 0, arst_n = 0, wdt_mode_wr = 0, deep_standby = 0, cpu_on_subclk = 0;
    logic wdt_irq_mask = 0, wdt_irq_priority = 0, wdt_irq_flag_clr = 0;
    logic wdt_irq_flag, wdt_interval_irq, wdt_interval_irq_prio, wdt_nmi, wdt_sys_reset;
    logic [7:0] wdt_mode_wdata = 8'h00, wdt_mode_reg;
    wit_pkg::wit_sel_t sel = 3'h1; // Changed only while stopped
    int n_errors = 0, tests_run = 0, n;
    wire ev = wdt_interval_irq | wdt_nmi | wdt_sys_reset;
    always #10 clk_sys = ~clk_sys;
    wit_timer u_dut (.clk_sys, .arst_n, .wdt_mode_wr, .wdt_mode_wdata, .wdt_mode_reg,
        .timer_clk_select_two(sel), .deep_standby, .cpu_on_subclk, .wdt_irq_mask,
        .wdt_irq_priority, .wdt_irq_flag_clr, .wdt_irq_flag, .wdt_interval_irq,
        .wdt_interval_irq_prio, .wdt_nmi, .wdt_sys_reset);
    ////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(string nm, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s exp %0h seen %0h", nm, e, s);
        end
    endtask
    task wr(logic [7:0] d);
        wdt_mode_wdata = d;
        wdt_mode_wr = 1;
        @(negedge clk_sys);
        wdt_mode_wr = 0;
    endtask
    // Bounded: a lost event ends the run
    task wt;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (!ev && n < 9000);
        if (!ev) begin
            n_errors++;
            report_and_stop();
        end
    endtask
    task quiet(int c);
        repeat (c) begin
            @(negedge clk_sys);
            chk("idle", ev, 0);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge clk_sys);
        arst_n = 1;
        chk("mode", wdt_mode_reg, 8'h00);
        wr(8'h80);
        wt;
        chk("first", n > 6140 && n < 8200, 1);
        chk("prio", wdt_interval_irq_prio, 0);
        wdt_irq_priority = 1;
        wt;
        chk("interval", n, 8192);
        chk("prio", wdt_interval_irq_prio, 1);
        chk("irq", wdt_interval_irq, 1);
        chk("flag", wdt_irq_flag, 1);
        wr(8'h00);
        chk("run", wdt_mode_reg, 8'h80);
        wdt_irq_mask = 1;
        quiet(8300);
        wdt_irq_mask = 0;
        wr(8'h90);
        chk("nmi", wdt_nmi, 1);
        wdt_irq_flag_clr = 1;
        @(negedge clk_sys);
        wdt_irq_flag_clr = 0;
        wt;
        wt;
        chk("detect", n, 4096);
        chk("nmi", wdt_nmi, 1);
        wr(8'h98);
        wt;
        chk("rst", wdt_sys_reset, 1);
        // Restarts well inside the window keep it quiet
        repeat (4) begin
            quiet(1900);
            wr(8'h80);
        end
        chk("sticky", wdt_mode_reg, 8'h98);
        deep_standby = 1;
        quiet(5000);
        deep_standby = 0;
        cpu_on_subclk = 1;
        quiet(5000);
        // Mid-run reset clears sticky bits; fastest watchdog code next
        arst_n = 0;
        cpu_on_subclk = 0;
        sel = 3'h0;
        repeat (2) @(negedge clk_sys);
        arst_n = 1;
        chk("reset", wdt_mode_reg, 8'h00);
        wr(8'h90);
        wt;
        wt;
        chk("detect0", n, 2048);
        chk("nmi0", wdt_nmi, 1);
        report_and_stop();
    end
endmodule
